// *** tel_pkg.sv ***
// How it works
// - S2 blocks frames, reference offset forced 127
// - S3 halts bus, monitor set until reconfig
// - highest severity wins; level change, S3 events, new overflow, every up-step of a tx count or exclusive rx count ending at 7 flag change
// - config error sets level 11
// - missing reference at watch trigger sets 11
// - watchdog timeout in time-triggered modes stops communication, level 11
// - bus-off sets level 11, status and init
// - tx count reaching 7 sets level 10
// - tx trigger over expected count sets 10
// - status spread over 2 or rx 7 sets 01
// - too few tx triggers at cycle start sets 01
// - reference identifier used for send and filter
// - generated bytes: one at level 1, else four
// - buffer 0 supplies rest when selected and pending
// - rx trigger in schedule (syncInSchedule) decrements on filter match, else increments
// - filter result cleared at rx trigger, cycle start
// - tx outcome steps the status count
// - time-triggered modes: 32 buffers, no fifo
`default_nettype none
package tel_pkg;
  typedef logic [1:0] tel_lvl_t;
  localparam tel_lvl_t LVL_S0 = 2'h0;
  localparam tel_lvl_t LVL_S1 = 2'h1;
  localparam tel_lvl_t LVL_S2 = 2'h2;
  localparam tel_lvl_t LVL_S3 = 2'h3;
  localparam logic [2:0] MSC_MAX = 3'h7;
  localparam logic [2:0] MSC_SPREAD = 3'h2;
  localparam logic [6:0] RTO_MAX = 7'h7F;
  localparam logic [1:0] OM_LEVEL1 = 2'h1;
  localparam logic [1:0] OM_LEVEL2 = 2'h2;
  localparam logic [1:0] OM_LEVEL0 = 2'h3;
  localparam int TX_BUFFERS = 32;
  localparam logic [3:0] GEN_BYTES_L1 = 4'h1;
  localparam logic [3:0] GEN_BYTES_L02 = 4'h4;
  localparam logic [3:0] REF_MAX_BYTES = 4'h8;
  localparam logic [3:0] REF_L02_BYTES = 4'h6;
  typedef enum logic [2:0] {
    TRG_RX = 3'h1,
    TRG_TX = 3'h2,
    TRG_OTHER = 3'h4
  } tel_trg_t;
  typedef enum logic [3:0] {
    TXR_NONE = 4'h0,
    TXR_OK = 4'h1,
    TXR_FAIL = 4'h2,
    TXR_BUSY = 4'h4,
    TXR_DISABLED = 4'h8
  } tel_txr_t;
  function automatic logic [2:0] mscStep(input logic [2:0] v, input logic up);
    if (up) begin
      mscStep = (v == MSC_MAX) ? v : v + 3'h1;
    end else begin
      mscStep = (v == 3'h0) ? v : v - 3'h1;
    end
  endfunction
endpackage
`default_nettype wire

// *** tel_byte_if.sv ***
`default_nettype none
interface tel_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** tel_fifo.sv ***
`default_nettype none
module tel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  tel_byte_if.snk   inPort,
  tel_byte_if.src   outPort,
  output var  logic fifoFull,
  output var  logic fifoEmpty
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH != 8) $error("fifo depth power of two, width 8");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic [AW:0]      wrPtr_next;
  logic [AW:0]      rdPtr_next;
  logic             doWr;
  logic             doRd;
  always_comb begin
    fifoFull = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    fifoEmpty = (wrPtr_reg == rdPtr_reg);
    inPort.ready = !fifoFull;
    outPort.valid = !fifoEmpty;
    outPort.data = mem[rdPtr_reg[AW-1:0]];
    doWr = inPort.valid && !fifoFull;
    doRd = outPort.ready && !fifoEmpty;
    wrPtr_next = wrPtr_reg + (AW+1)'(doWr);
    rdPtr_next = rdPtr_reg + (AW+1)'(doRd);
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_reg[AW-1:0]] <= inPort.data;
    end
  end
endmodule
`default_nettype wire

// *** tel_msc_mem.sv ***
`default_nettype none
module tel_msc_mem #(
  parameter int ENTRIES = 64
) (
  input  wire logic                       ref_clk,
  input  wire logic                       wrEn,
  input  wire logic [$clog2(ENTRIES)-1:0] wrAddr,
  input  wire logic [2:0]                 wrData,
  input  wire logic [$clog2(ENTRIES)-1:0] rdAddr,
  output var  logic [2:0]                 rdData
);
  logic [2:0] store [ENTRIES];
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end
endmodule
`default_nettype wire

// *** tel_core.sv ***
`default_nettype none
module tel_core
  import tel_pkg::*;
#(
  parameter int ELEMENTS = 64
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [1:0]                  operationMode,
  input  wire logic                        configChangeEnable,
  input  wire logic [7:0]                  appWatchdogLimit,
  input  wire logic                        appWatchdogTick,
  input  wire logic                        statusRead,
  input  wire logic                        configErrorEvt,
  input  wire logic                        watchTriggerEvt,
  input  wire logic                        busOffEvt,
  input  wire logic                        matrixCycleStart,
  input  wire logic                        basicCycleStart,
  input  wire logic                        syncInSchedule,
  input  wire logic [7:0]                  expectedTxTriggerCount,
  input  wire logic                        trigStrobe,
  input  wire tel_pkg::tel_trg_t           trigType,
  input  wire logic                        trigExclusive,
  input  wire logic [$clog2(ELEMENTS)-1:0] trigIndex,
  input  wire logic [6:0]                  trigFilterNum,
  input  wire logic                        filterMatchValid,
  input  wire logic [6:0]                  filterMatchNum,
  input  wire tel_pkg::tel_txr_t           txResult,
  input  wire logic [$clog2(ELEMENTS)-1:0] txResultIndex,
  input  wire logic [28:0]                 refIdentifier,
  input  wire logic                        refPayloadSelect,
  input  wire logic                        buffer0Pending,
  input  wire logic [3:0]                  buffer0Dlc,
  input  wire logic [63:0]                 buffer0Data,
  input  wire logic [31:0]                 frameSyncBytes,
  input  wire logic                        refStart,
  input  wire logic                        rxIdValid,
  input  wire logic [28:0]                 rxId,
  input  wire logic                        refByteReady,
  output var  logic [1:0]                  errorLevel,
  output var  logic                        errorLevelChanged,
  output var  logic                        schedError1,
  output var  logic                        schedError2,
  output var  logic                        txOverflow,
  output var  logic                        txUnderflow,
  output var  logic                        appWatchdogError,
  output var  logic                        appWatchdogFlag,
  output var  logic                        busMonitor,
  output var  logic                        busOffStatus,
  output var  logic                        initBit,
  output var  logic                        txFramesEnable,
  output var  logic                        dominantEnable,
  output var  logic [6:0]                  refTriggerOffsetCap,
  output var  logic                        txFifoAvailable,
  output var  logic                        refIdMatch,
  output var  logic [28:0]                 refTxId,
  output var  logic [3:0]                  refDlc,
  output var  logic                        refByteValid,
  output var  logic [7:0]                  refByte
);
  import tel_pkg::*;
  localparam int IW = $clog2(ELEMENTS);
  initial begin
    if (ELEMENTS < 2) $error("ELEMENTS too small");
  end

  // error level state
  tel_lvl_t   lvl_reg, lvl_next;
  logic       elc_reg, elc_next, se1_reg, se1_next, se2_reg, se2_next;
  logic       txo_reg, txo_next, txu_reg, txu_next, awe_reg, awe_next;
  logic       awf_reg, awf_next, mon_reg, mon_next, bo_reg, bo_next;
  logic [7:0] awCnt_reg, awCnt_next, txCnt_reg, txCnt_next;
  logic       sawTx7_reg, sawTx7_next, sawS1_reg, sawS1_next;
  logic [2:0] mscMax_reg, mscMax_next, mscMin_reg, mscMin_next;
  // status count state
  logic [6:0] afr_reg, afr_next;
  logic       afrValid_reg, afrValid_next;
  logic       pend_reg, pend_next, pendUp_reg, pendUp_next, pendRx_reg, pendRx_next, pendEx_reg, pendEx_next;
  logic [IW-1:0] pendIdx_reg, pendIdx_next, clrIdx_reg, clrIdx_next;
  logic [2:0] mscNew;
  logic [2:0] mscRd;
  logic       s3Evt;
  logic       tx7Evt, s1Evt;
  // reference payload state
  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_SEND = 3'h2,
    RS_DRAIN = 3'h4
  } tel_rs_t;
  tel_rs_t    rs_reg, rs_next;
  logic [3:0] rIdx_reg, rIdx_next, rLen_reg, rLen_next;
  logic [63:0] rData_reg, rData_next;
  logic       ttMode;
  tel_byte_if refIn ();
  tel_byte_if refOut ();

  assign ttMode = (operationMode == OM_LEVEL1) || (operationMode == OM_LEVEL2);

  tel_msc_mem #(.ENTRIES(ELEMENTS)) uMsc (
    .ref_clk (ref_clk),
    .wrEn    (pend_reg || configChangeEnable),
    .wrAddr  (configChangeEnable ? clrIdx_reg : pendIdx_reg),
    .wrData  (configChangeEnable ? '0 : mscNew),
    .rdAddr  (trigStrobe ? trigIndex : txResultIndex),
    .rdData  (mscRd)
  );

  tel_fifo #(.WIDTH(8), .DEPTH(8)) uFifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .inPort    (refIn.snk),
    .outPort   (refOut.src),
    .fifoFull  (),
    .fifoEmpty ()
  );

  always_comb begin
    // status count update, one cycle after memory read
    mscNew = mscStep(mscRd, pendUp_reg);
    tx7Evt = pend_reg && !pendRx_reg && pendUp_reg && (mscNew == MSC_MAX);
    s1Evt = pend_reg && pendRx_reg && pendEx_reg && pendUp_reg && (mscNew == MSC_MAX);
    pend_next = 1'b0;
    pendUp_next = 1'b0;
    pendRx_next = 1'b0;
    pendEx_next = trigExclusive;
    pendIdx_next = trigIndex;
    clrIdx_next = configChangeEnable ? clrIdx_reg + 1'b1 : '0;
    afr_next = afr_reg;
    afrValid_next = afrValid_reg && !basicCycleStart;
    if (filterMatchValid) begin
      afr_next = filterMatchNum;
      afrValid_next = 1'b1;
    end
    if (trigStrobe && trigType == TRG_RX) begin
      pend_next = syncInSchedule;
      pendRx_next = 1'b1;
      pendUp_next = !(afrValid_next && afr_next == trigFilterNum);
      afrValid_next = 1'b0;
    end else if (txResult != TXR_NONE) begin
      pend_next = 1'b1;
      pendIdx_next = txResultIndex;
      pendEx_next = 1'b1;
      pendUp_next = (txResult == TXR_FAIL) || (txResult == TXR_BUSY);
    end
  end

  always_comb begin
    s3Evt = configErrorEvt || watchTriggerEvt || busOffEvt;
    awCnt_next = awCnt_reg;
    awe_next = awe_reg;
    awf_next = awf_reg;
    if (statusRead) begin
      awCnt_next = 8'h00;
    end else if (appWatchdogTick && awCnt_reg != 8'hFF) begin
      awCnt_next = awCnt_reg + 8'h01;
    end
    if (ttMode && awCnt_reg > appWatchdogLimit && appWatchdogLimit != 8'h00) begin
      awe_next = 1'b1;
      awf_next = 1'b1;
    end
    txCnt_next = txCnt_reg;
    txo_next = txo_reg;
    txu_next = txu_reg;
    se1_next = se1_reg;
    se2_next = se2_reg;
    sawTx7_next = sawTx7_reg || tx7Evt;
    sawS1_next = sawS1_reg || s1Evt;
    mscMax_next = mscMax_reg;
    mscMin_next = mscMin_reg;
    if (pend_reg && pendEx_reg) begin
      mscMax_next = (mscNew > mscMax_reg) ? mscNew : mscMax_reg;
      mscMin_next = (mscNew < mscMin_reg) ? mscNew : mscMin_reg;
    end
    lvl_next = lvl_reg;
    elc_next = 1'b0;
    if (trigStrobe && trigType == TRG_TX) begin
      if (txCnt_reg >= expectedTxTriggerCount) begin
        txo_next = 1'b1;
        if (lvl_next < LVL_S2) lvl_next = LVL_S2;
      end
      txCnt_next = txCnt_reg + 8'h01;
    end
    if (tx7Evt) begin
      se2_next = 1'b1;
      if (lvl_next < LVL_S2) lvl_next = LVL_S2;
    end
    if (s1Evt || (mscMax_next - mscMin_next > MSC_SPREAD && mscMax_next >= mscMin_next)) begin
      se1_next = 1'b1;
      sawS1_next = 1'b1;
      if (lvl_next < LVL_S1) lvl_next = LVL_S1;
    end
    if (matrixCycleStart && lvl_reg != LVL_S3) begin
      // re-grade from what the finished cycle showed
      lvl_next = LVL_S0;
      if (txCnt_next < expectedTxTriggerCount) begin
        txu_next = 1'b1;
        lvl_next = LVL_S1;
      end
      if (sawS1_next) lvl_next = LVL_S1;
      if (sawTx7_next || txCnt_next > expectedTxTriggerCount) lvl_next = LVL_S2;
      txCnt_next = 8'h00;
      sawTx7_next = 1'b0;
      sawS1_next = 1'b0;
      mscMax_next = 3'h0;
      mscMin_next = MSC_MAX;
    end
    if (s3Evt || awe_next) begin
      lvl_next = LVL_S3;
    end
    if (lvl_reg == LVL_S3 && configChangeEnable && !s3Evt && (awe_reg || !awe_next)) begin
      lvl_next = LVL_S0;
      awe_next = 1'b0;
      awCnt_next = 8'h00;
    end
    if (lvl_next != lvl_reg || s3Evt || txo_next != txo_reg || tx7Evt || s1Evt) begin
      elc_next = 1'b1;
    end
    mon_next = (mon_reg && !configChangeEnable) || (lvl_next == LVL_S3);
    bo_next = busOffEvt || (bo_reg && !configChangeEnable);
  end

  // reference message payload build
  always_comb begin
    rs_next = rs_reg;
    rIdx_next = rIdx_reg;
    rLen_next = rLen_reg;
    rData_next = rData_reg;
    refIn.valid = 1'b0;
    refIn.data = rData_reg[7:0];
    case (rs_reg)
      RS_IDLE: begin
        if (refStart) begin
          rs_next = RS_SEND;
          rIdx_next = 4'h0;
          if (operationMode == OM_LEVEL1) begin
            rData_next = {buffer0Data[63:8], frameSyncBytes[7:0]};
            rLen_next = GEN_BYTES_L1;
          end else begin
            rData_next = {buffer0Data[63:32], frameSyncBytes};
            rLen_next = GEN_BYTES_L02;
          end
          if (refPayloadSelect && buffer0Pending && buffer0Dlc > rLen_next) begin
            rLen_next = (buffer0Dlc > REF_MAX_BYTES) ? REF_MAX_BYTES : buffer0Dlc;
            if (operationMode != OM_LEVEL1 && rLen_next > REF_L02_BYTES) rLen_next = REF_L02_BYTES;
          end
        end
      end
      RS_SEND: begin
        refIn.valid = 1'b1;
        if (refIn.ready) begin
          rData_next = {8'h00, rData_reg[63:8]};
          rIdx_next = rIdx_reg + 4'h1;
          if (rIdx_next == rLen_reg) rs_next = RS_DRAIN;
        end
      end
      RS_DRAIN: rs_next = RS_IDLE;
      default: rs_next = RS_IDLE;
    endcase
    refOut.ready = refByteReady;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_reg <= LVL_S0; elc_reg <= 1'b0; se1_reg <= 1'b0; se2_reg <= 1'b0;
      txo_reg <= 1'b0; txu_reg <= 1'b0; awe_reg <= 1'b0; awf_reg <= 1'b0;
      mon_reg <= 1'b0; bo_reg <= 1'b0; awCnt_reg <= 8'h00; txCnt_reg <= 8'h00;
      sawTx7_reg <= 1'b0; sawS1_reg <= 1'b0; mscMax_reg <= 3'h0; mscMin_reg <= MSC_MAX;
      afr_reg <= 7'h00; afrValid_reg <= 1'b0; pend_reg <= 1'b0; pendUp_reg <= 1'b0;
      pendRx_reg <= 1'b0; pendEx_reg <= 1'b0; pendIdx_reg <= '0; clrIdx_reg <= '0;
      rs_reg <= RS_IDLE; rIdx_reg <= 4'h0; rLen_reg <= 4'h0; rData_reg <= 64'h0;
    end else begin
      lvl_reg <= lvl_next; elc_reg <= elc_next; se1_reg <= se1_next; se2_reg <= se2_next;
      txo_reg <= txo_next; txu_reg <= txu_next; awe_reg <= awe_next; awf_reg <= awf_next;
      mon_reg <= mon_next; bo_reg <= bo_next; awCnt_reg <= awCnt_next; txCnt_reg <= txCnt_next;
      sawTx7_reg <= sawTx7_next; sawS1_reg <= sawS1_next; mscMax_reg <= mscMax_next; mscMin_reg <= mscMin_next;
      afr_reg <= afr_next; afrValid_reg <= afrValid_next; pend_reg <= pend_next; pendUp_reg <= pendUp_next;
      pendRx_reg <= pendRx_next; pendEx_reg <= pendEx_next; pendIdx_reg <= pendIdx_next; clrIdx_reg <= clrIdx_next;
      rs_reg <= rs_next; rIdx_reg <= rIdx_next; rLen_reg <= rLen_next; rData_reg <= rData_next;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      errorLevel <= LVL_S0; errorLevelChanged <= 1'b0; schedError1 <= 1'b0; schedError2 <= 1'b0;
      txOverflow <= 1'b0; txUnderflow <= 1'b0; appWatchdogError <= 1'b0; appWatchdogFlag <= 1'b0;
      busMonitor <= 1'b0; busOffStatus <= 1'b0; initBit <= 1'b0; txFramesEnable <= 1'b0;
      dominantEnable <= 1'b0; refTriggerOffsetCap <= RTO_MAX; txFifoAvailable <= 1'b1;
      refIdMatch <= 1'b0; refTxId <= 29'h0; refDlc <= 4'h0; refByteValid <= 1'b0; refByte <= 8'h00;
    end else begin
      errorLevel <= lvl_next;
      errorLevelChanged <= elc_next;
      schedError1 <= se1_next;
      schedError2 <= se2_next;
      txOverflow <= txo_next;
      txUnderflow <= txu_next;
      appWatchdogError <= awe_next;
      appWatchdogFlag <= awf_next;
      busMonitor <= mon_next;
      busOffStatus <= bo_next;
      initBit <= bo_next;
      txFramesEnable <= lvl_next < LVL_S2;
      dominantEnable <= !mon_next;
      refTriggerOffsetCap <= (lvl_next == LVL_S2) ? RTO_MAX : 7'h00;
      txFifoAvailable <= !ttMode;
      refIdMatch <= rxIdValid && (rxId == refIdentifier);
      refTxId <= refIdentifier;
      refDlc <= (rs_reg == RS_IDLE) ? refDlc : rLen_reg;
      refByteValid <= refOut.valid && refByteReady;
      refByte <= refOut.data;
    end
  end

  AST_S3_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    errorLevel == LVL_S3 && !configChangeEnable |=> errorLevel == LVL_S3)
    else $error("S3 left without config change");
  AST_S3_MON: assert property (@(posedge ref_clk) disable iff (!arst_n)
    errorLevel == LVL_S3 |-> busMonitor && !dominantEnable && !txFramesEnable)
    else $error("S3 without monitor");
  AST_BUSOFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    busOffEvt |=> errorLevel == LVL_S3 && busOffStatus && initBit)
    else $error("bus-off not reported");
  AST_WATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    watchTriggerEvt |=> errorLevel == LVL_S3 && errorLevelChanged)
    else $error("watch trigger not S3");
  AST_S2_RTO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    errorLevel == LVL_S2 |-> refTriggerOffsetCap == RTO_MAX && !txFramesEnable)
    else $error("S2 offset or frames wrong");
  AST_TXO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    trigStrobe && trigType == TRG_TX && txCnt_reg >= expectedTxTriggerCount && !configChangeEnable
    |=> txOverflow && errorLevel >= LVL_S2)
    else $error("overflow missed");
  AST_MODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ttMode |=> !txFifoAvailable)
    else $error("fifo offered in tt mode");
  AST_AFR_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    basicCycleStart && !filterMatchValid |=> !afrValid_reg)
    else $error("filter result not cleared");
  AST_SAT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pend_reg && pendUp_reg && mscRd == MSC_MAX |-> mscNew == MSC_MAX)
    else $error("count wrapped");
endmodule
`default_nettype wire

// *** tel_sink_model.sv ***
`default_nettype none
module tel_sink_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       refByteValid,
  input  wire logic [7:0] refByte,
  input  wire logic       stall,
  output var  logic       refByteReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  // ready held low while stalled or in reset
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) refByteReady <= 1'b0;
    else refByteReady <= !stall;
  end
  // one byte taken per valid cycle
  always @(posedge ref_clk) begin
    if (arst_n && refByteValid === 1'b1) got.push_back(refByte);
  end
endmodule
`default_nettype wire

// *** tel_core_tb.sv ***
`default_nettype none
module tel_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tel_pkg::*;
  logic        ref_clk, arst_n, configChangeEnable, appWatchdogTick, statusRead, configErrorEvt;
  logic        watchTriggerEvt, busOffEvt, matrixCycleStart, basicCycleStart, syncInSchedule;
  logic        trigStrobe, trigExclusive, filterMatchValid, refPayloadSelect, buffer0Pending;
  logic        refStart, rxIdValid, refByteReady, stall, sawChange;
  logic [1:0]  operationMode, errorLevel;
  logic [7:0]  appWatchdogLimit, expectedTxTriggerCount, refByte;
  tel_trg_t    trigType;
  tel_txr_t    txResult;
  logic [5:0]  trigIndex, txResultIndex;
  logic [6:0]  trigFilterNum, filterMatchNum, refTriggerOffsetCap;
  logic [28:0] refIdentifier, rxId, refTxId;
  logic [3:0]  buffer0Dlc, refDlc;
  logic [63:0] buffer0Data;
  logic [31:0] frameSyncBytes;
  logic        errorLevelChanged, schedError1, schedError2, txOverflow, txUnderflow;
  logic        appWatchdogError, appWatchdogFlag, busMonitor, busOffStatus, initBit;
  logic        txFramesEnable, dominantEnable, txFifoAvailable, refIdMatch, refByteValid;
  int          n_mismatch, n_checks, cyc, gen, nb;

  tel_core dut (.*);
  tel_sink_model sink (.ref_clk, .arst_n, .refByteValid, .refByte, .stall, .refByteReady);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (errorLevelChanged === 1'b1) sawChange = 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic done(input string m);
    $display("test %s done", m);
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    tick(8);
    arst_n = 1'b1;
    configChangeEnable = 1'b1;
    tick(64);
    configChangeEnable = 1'b0;
    sawChange = 1'b0;
    tick();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick(2);
  endtask
  task automatic trig(input tel_trg_t t, input logic [5:0] idx, input logic [6:0] f);
    trigType = t;
    trigIndex = idx;
    trigFilterNum = f;
    trigStrobe = 1'b1;
    tick();
    trigStrobe = 1'b0;
    tick(3);
  endtask
  task automatic txr(input tel_txr_t r, input logic [5:0] idx);
    txResult = r;
    txResultIndex = idx;
    tick();
    txResult = TXR_NONE;
    tick(3);
  endtask

  initial begin
    {arst_n, configChangeEnable, appWatchdogTick, statusRead, configErrorEvt, watchTriggerEvt} = '0;
    {busOffEvt, matrixCycleStart, basicCycleStart, syncInSchedule, trigStrobe, filterMatchValid} = '0;
    {refPayloadSelect, buffer0Pending, refStart, rxIdValid, stall, appWatchdogLimit} = '0;
    {trigIndex, txResultIndex, trigFilterNum, filterMatchNum, expectedTxTriggerCount, rxId} = '0;
    trigExclusive = 1'b1;
    trigType = TRG_OTHER;
    txResult = TXR_NONE;
    operationMode = OM_LEVEL1;
    refIdentifier = 29'h0ABCDEF1;
    buffer0Dlc = 4'h8;
    buffer0Data = 64'hF8F7F6F5F4F3F2F1;
    frameSyncBytes = 32'hA4A3A2A1;
    do_reset();
    pulse(configErrorEvt);
    chk(errorLevel, 3, "cfg err");
    chk(sawChange, 1, "lvl change");
    do_reset();
    pulse(watchTriggerEvt);
    chk(errorLevel, 3, "watch");
    pulse(matrixCycleStart);
    chk(errorLevel, 3, "s3 held");
    chk(dominantEnable, 0, "no dominant");
    pulse(busOffEvt);
    chk({busOffStatus, initBit, busMonitor}, 3'h7, "bus off");
    configChangeEnable = 1'b1;
    tick(3);
    configChangeEnable = 1'b0;
    tick(2);
    chk({errorLevel, busMonitor, busOffStatus}, 0, "reconfig");
    done("severe");
    do_reset();
    appWatchdogLimit = 8'h03;
    for (int i = 0; i < 6; i++) begin
      pulse(appWatchdogTick);
      pulse(statusRead);
    end
    chk(appWatchdogError, 0, "wd served");
    for (int i = 0; i < 5; i++) pulse(appWatchdogTick);
    chk({appWatchdogError, appWatchdogFlag, busMonitor, errorLevel}, 5'h1F, "wd timeout");
    appWatchdogLimit = 8'h00;
    done("watchdog");
    do_reset();
    expectedTxTriggerCount = 8'h02;
    pulse(matrixCycleStart);
    chk({txUnderflow, errorLevel}, 3'h5, "underflow");
    expectedTxTriggerCount = 8'h00;
    trig(TRG_TX, 6'h01, 7'h00);
    chk({txOverflow, errorLevel}, 3'h6, "overflow");
    chk({refTriggerOffsetCap, txFramesEnable}, {RTO_MAX, 1'b0}, "s2 block");
    done("tx count");
    do_reset();
    expectedTxTriggerCount = 8'hFF;
    for (int i = 0; i < 8; i++) txr(tel_txr_t'(i[0] ? TXR_OK : TXR_DISABLED), 6'h05);
    for (int i = 0; i < 6; i++) txr(tel_txr_t'(i[0] ? TXR_FAIL : TXR_BUSY), 6'h05);
    chk(schedError2, 0, "msc 6");
    txr(TXR_FAIL, 6'h05);
    chk({schedError2, errorLevel}, 3'h6, "msc 7");
    done("tx status");
    do_reset();
    syncInSchedule = 1'b1;
    filterMatchNum = 7'h03;
    for (int i = 0; i < 8; i++) begin
      pulse(filterMatchValid);
      trig(TRG_RX, 6'h09, 7'h03);
    end
    chk(schedError1, 0, "rx matched");
    pulse(filterMatchValid);
    pulse(basicCycleStart);
    for (int i = 0; i < 7; i++) trig(TRG_RX, 6'h09, 7'h03);
    chk({schedError1, errorLevel}, 3'h5, "rx msc 7");
    done("rx status");
    for (int c = 0; c < 4; c++) begin
      operationMode = (c == 0) ? OM_LEVEL2 : (c < 3) ? OM_LEVEL1 : OM_LEVEL0;
      do_reset();
      gen = (operationMode == OM_LEVEL1) ? 1 : 4;
      refPayloadSelect = (c != 3);
      buffer0Pending = 1'b0;
      tick();
      buffer0Dlc = (c == 0) ? 4'h6 : 4'h8;
      buffer0Pending = (c != 1);
      nb = (refPayloadSelect && buffer0Pending) ? int'(buffer0Dlc) : gen;
      stall = (c == 2);
      sink.got.delete();
      pulse(refStart);
      tick(20);
      stall = 1'b0;
      for (int w = 0; w < 200 && sink.got.size() < nb; w++) tick();
      tick(4);
      chk(sink.got.size(), nb, "ref count");
      chk(refDlc, nb, "ref dlc");
      for (int k = 0; k < sink.got.size() && k < nb; k++)
        chk(sink.got[k], (k < gen) ? frameSyncBytes[8*k+:8] : buffer0Data[8*k+:8], "ref byte");
      chk(refTxId, refIdentifier, "ref id");
      chk(txFifoAvailable, c == 3, "tx fifo");
      rxId = refIdentifier;
      rxIdValid = 1'b1;
      tick(2);
      chk(refIdMatch, 1, "id match");
      rxId = ~refIdentifier;
      tick(2);
      chk(refIdMatch, 0, "id miss");
      rxIdValid = 1'b0;
    end
    done("reference");
    wrap_up();
  end
endmodule
`default_nettype wire
